// file: logic/cirq_flags.v
// Behaviour
// - Bit 8 resets to 1, is set when the internal reset sequence ends, and is cleared by writing 1.
// - The reset-done flag always raises an interrupt request and no mask bit can block it.
// - Bits 7 to 5 and 3 to 2 read as 0 and software writes only 0 to them.
// - Bit 4 is set by a dominant bit seen during sleep mode and is cleared by writing 1.
// - Bit 1 is read-only and is set whenever any unread-message status bit becomes set.
// - Bit 1 clears only when all unread-message status bits are clear; writes to it do nothing.
// - Bit 0 is set when a transmit-pending bit clears on send or abort completion; write 1 clears it.
// - Bit 0 drives the empty-slot request only while mask bit 0 is 0.
// - Bit 4 drives the overload-group request only while mask bit 4 is 0.
// - Bit 1 drives the overload-group request only while mask bit 1 is 0.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "cirq_regs.vh"
module cirq_flags
#(
	parameter NUM_MBOX = 16
)
(
	input  wire                clk,
	input  wire                nrst,
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [11:0]         paddr,
	input  wire [31:0]         pwdata,
	output reg  [31:0]         prdata,
	output reg                 pready,
	output reg                 pslverr,
	input  wire                sleepMode,
	input  wire                busDominant,
	input  wire                standbyExit,
	input  wire [NUM_MBOX-1:0] unreadMsgStatus,
	input  wire [NUM_MBOX-1:0] txPendingBits,
	input  wire [NUM_MBOX-1:0] txDoneClear,
	output reg                 resetDoneRequest,
	output reg                 overloadGroupRequest,
	output reg                 emptySlotRequest,
	output reg                 irq
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire        access;
	wire        wrFlags;
	wire        wrMask;
	wire        wrCtrl;
	wire        mapped;
	assign access  = psel & penable & ~pready;
	assign wrFlags = access & pwrite & (paddr == `CIRQ_OFS_FLAGS);
	assign wrMask  = access & pwrite & (paddr == `CIRQ_OFS_MASK);
	assign wrCtrl  = access & pwrite & (paddr == `CIRQ_OFS_CTRL);
	assign mapped  = (paddr == `CIRQ_OFS_FLAGS) | (paddr == `CIRQ_OFS_MASK) |
	                 (paddr == `CIRQ_OFS_CTRL) | (paddr == `CIRQ_OFS_STATUS);

	// ------------------------------------------------------------
	// Internal reset sequence
	// ------------------------------------------------------------
	localparam [1:0] RS_IDLE = 2'b01;
	localparam [1:0] RS_BUSY = 2'b10;
	reg  [1:0] rstState;
	reg  [1:0] next_rstState;
	reg  [3:0] rstCount;
	reg  [3:0] next_rstCount;
	wire       rstRestart;
	wire       rstBusy;
	wire       rstDoneEvt;
	// Standby exit or a control write with bit 0 set restarts the sequence
	assign rstRestart = standbyExit | (wrCtrl & pwdata[0]);
	// Next state; a restart while busy reloads the count
	always @*
	begin
		next_rstState = rstState;
		next_rstCount = rstCount;
		case (rstState)
			RS_IDLE:
			begin
				if (rstRestart)
				begin
					next_rstState = RS_BUSY;
					next_rstCount = `CIRQ_RST_SEQ_CYCLES;
				end
			end
			RS_BUSY:
			begin
				if (rstRestart)
					next_rstCount = `CIRQ_RST_SEQ_CYCLES;
				else if (rstCount == 4'h1)
				begin
					next_rstState = RS_IDLE;
					next_rstCount = 4'h0;
				end
				else
					next_rstCount = rstCount - 4'h1;
			end
			default:
			begin
				// Illegal code: rerun the sequence rather than hang
				next_rstState = RS_BUSY;
				next_rstCount = `CIRQ_RST_SEQ_CYCLES;
			end
		endcase
	end
	// Sequence registers; power-on starts busy
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rstState <= RS_BUSY;
			rstCount <= `CIRQ_RST_SEQ_CYCLES;
		end
		else
		begin
			rstState <= next_rstState;
			rstCount <= next_rstCount;
		end
	end
	assign rstBusy    = rstState[1];
	assign rstDoneEvt = rstBusy & (rstCount == 4'h1);

	// ------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------
	reg  [NUM_MBOX-1:0] txPendPrev;
	reg  [NUM_MBOX-1:0] unreadPrev;
	wire [NUM_MBOX-1:0] txFreeEvt;
	wire [NUM_MBOX-1:0] unreadRise;
	// Previous samples for edge detection
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			txPendPrev <= {NUM_MBOX{1'b0}};
			unreadPrev <= {NUM_MBOX{1'b0}};
		end
		else
		begin
			txPendPrev <= txPendingBits;
			unreadPrev <= unreadMsgStatus;
		end
	end
	// Per mailbox: pending fell and it was a send or abort completion
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MBOX; gi = gi + 1)
		begin : gEvt
			assign txFreeEvt[gi]  = txPendPrev[gi] & ~txPendingBits[gi] & txDoneClear[gi];
			assign unreadRise[gi] = unreadMsgStatus[gi] & ~unreadPrev[gi];
		end
	endgenerate

	wire wakeEvt;
	assign wakeEvt = sleepMode & busDominant;

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	wire rstDoneFlag;
	wire wakeFlag;
	wire txFreeFlag;
	reg  ovwrFlag;
	reg  next_ovwrFlag;
	wire clrRstDone;
	wire clrWake;
	wire clrTxFree;
	// Clear strobes; a zero bit in the write leaves its flag alone
	assign clrRstDone = wrFlags & pwdata[`CIRQ_BIT_RSTDONE];
	assign clrWake    = wrFlags & pwdata[`CIRQ_BIT_WAKE];
	assign clrTxFree  = wrFlags & pwdata[`CIRQ_BIT_TXFREE];

	cirq_w1c_flag #(.RST_VAL(1'b1)) uRstDone
	(
		.clk    (clk),
		.nrst   (nrst),
		.setEvt (rstDoneEvt),
		.clrEvt (clrRstDone),
		.flag   (rstDoneFlag)
	);
	cirq_w1c_flag #(.RST_VAL(1'b0)) uWake
	(
		.clk    (clk),
		.nrst   (nrst),
		.setEvt (wakeEvt),
		.clrEvt (clrWake),
		.flag   (wakeFlag)
	);
	cirq_w1c_flag #(.RST_VAL(1'b0)) uTxFree
	(
		.clk    (clk),
		.nrst   (nrst),
		.setEvt (|txFreeEvt),
		.clrEvt (clrTxFree),
		.flag   (txFreeFlag)
	);

	// Overwrite flag follows status; bus writes never touch it
	always @*
	begin
		next_ovwrFlag = ovwrFlag;
		if (|unreadRise)
			next_ovwrFlag = 1'b1;
		else if (~|unreadMsgStatus)
			next_ovwrFlag = 1'b0;
	end
	// Overwrite flag register
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ovwrFlag <= 1'b0;
		else
			ovwrFlag <= next_ovwrFlag;
	end

	// ------------------------------------------------------------
	// Mask register
	// ------------------------------------------------------------
	reg  [15:0] maskReg;
	reg  [15:0] next_maskReg;
	// Only bits 4, 1, 0 are writable; the rest read as set
	always @*
	begin
		next_maskReg = maskReg;
		if (wrMask)
			next_maskReg = (pwdata[15:0] & `CIRQ_MASK_WMASK) | ~`CIRQ_MASK_WMASK;
	end
	// Mask register; reset masks every request but the reset-done one
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			maskReg <= `CIRQ_MASK_RST;
		else
			maskReg <= next_maskReg;
	end

	// ------------------------------------------------------------
	// Flag word, reserved bits forced to zero
	// ------------------------------------------------------------
	wire [15:0] flagWord;
	genvar gb;
	// One bit per position; anything not a flag reads as zero
	generate
		for (gb = 0; gb < 16; gb = gb + 1)
		begin : gWord
			if (gb == `CIRQ_BIT_RSTDONE)
			begin : gRst
				assign flagWord[gb] = rstDoneFlag;
			end
			else if (gb == `CIRQ_BIT_WAKE)
			begin : gWake
				assign flagWord[gb] = wakeFlag;
			end
			else if (gb == `CIRQ_BIT_OVWR)
			begin : gOvwr
				assign flagWord[gb] = ovwrFlag;
			end
			else if (gb == `CIRQ_BIT_TXFREE)
			begin : gTx
				assign flagWord[gb] = txFreeFlag;
			end
			else
			begin : gRsvd
				assign flagWord[gb] = 1'b0;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Request outputs, registered
	// ------------------------------------------------------------
	wire next_resetDone;
	wire next_overload;
	wire next_emptySlot;
	assign next_resetDone = rstDoneFlag;
	assign next_overload  = (wakeFlag & ~maskReg[`CIRQ_BIT_WAKE]) |
	                        (ovwrFlag & ~maskReg[`CIRQ_BIT_OVWR]);
	assign next_emptySlot = txFreeFlag & ~maskReg[`CIRQ_BIT_TXFREE];
	// One-cycle lag from flag to request; flags are sticky so nothing is missed
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			resetDoneRequest     <= 1'b0;
			overloadGroupRequest <= 1'b0;
			emptySlotRequest     <= 1'b0;
			irq                  <= 1'b0;
		end
		else
		begin
			resetDoneRequest     <= next_resetDone;
			overloadGroupRequest <= next_overload;
			emptySlotRequest     <= next_emptySlot;
			irq                  <= next_resetDone | next_overload | next_emptySlot;
		end
	end

	// ------------------------------------------------------------
	// APB slave: one wait state, reads registered
	// ------------------------------------------------------------
	reg [31:0] next_prdata;
	always @*
	begin
		next_prdata = 32'h00000000;
		case (paddr)
			`CIRQ_OFS_FLAGS:  next_prdata = {16'h0000, flagWord};
			`CIRQ_OFS_MASK:   next_prdata = {16'h0000, maskReg};
			`CIRQ_OFS_STATUS: next_prdata = {31'h00000000, rstBusy};
			default:          next_prdata = 32'h00000000;
		endcase
	end
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= access;
			pslverr <= access & ~mapped;
			prdata  <= (access & ~pwrite) ? next_prdata : 32'h00000000;
		end
	end
endmodule // cirq_flags

// file: logic/cirq_regs.vh
`ifndef CIRQ_REGS_VH
`define CIRQ_REGS_VH
// ------------------------------------------------------------
// Register map, byte addresses on APB
// ------------------------------------------------------------
`define CIRQ_OFS_FLAGS      12'h000
`define CIRQ_OFS_MASK       12'h004
`define CIRQ_OFS_CTRL       12'h008
`define CIRQ_OFS_STATUS     12'h00c
// ------------------------------------------------------------
// Flag bit positions
// ------------------------------------------------------------
`define CIRQ_BIT_TXFREE     0
`define CIRQ_BIT_OVWR       1
`define CIRQ_BIT_WAKE       4
`define CIRQ_BIT_RSTDONE    8
// ------------------------------------------------------------
// Reset values and write masks
// ------------------------------------------------------------
`define CIRQ_FLAGS_RST      16'h0100
`define CIRQ_MASK_RST       16'hffff
`define CIRQ_FLAGS_WMASK    16'h0111
`define CIRQ_MASK_WMASK     16'h0013
// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define CIRQ_RST_SEQ_CYCLES 4'h4
`endif

// file: logic/cirq_w1c_flag.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// Sticky write-one-to-clear flag
// ------------------------------------------------------------
module cirq_w1c_flag
#(
	parameter RST_VAL = 1'b0
)
(
	input  wire clk,
	input  wire nrst,
	input  wire setEvt,
	input  wire clrEvt,
	output reg  flag
);
	// Set beats clear so no event is lost in a clearing cycle
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			flag <= RST_VAL;
		else if (setEvt)
			flag <= 1'b1;
		else if (clrEvt)
			flag <= 1'b0;
	end
endmodule // cirq_w1c_flag

// file: testbench/cirq_flags_props.sv
`timescale 1ns/1ps
module cirq_flags_chk
#(
	parameter NUM_MBOX = 16
)
(
	input wire                clk,
	input wire                nrst,
	input wire                psel,
	input wire                penable,
	input wire                pwrite,
	input wire [11:0]         paddr,
	input wire [31:0]         pwdata,
	input wire [31:0]         prdata,
	input wire                pready,
	input wire                pslverr,
	input wire [NUM_MBOX-1:0] unreadMsgStatus,
	input wire                resetDoneRequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Flag reads and reset-flag clears as seen on the bus
	wire rdF = pready && !pwrite && paddr == 12'h000;
	wire clr8 = psel && penable && pwrite && !pready && paddr == 12'h000 && pwdata[8];
	property p_rdy; psel && penable && !pready |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held");
	property p_idle; !pready |-> prdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
	property p_err; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h00c); endproperty
	a_err: assert property (p_err) else $error("bad error flag");
	property p_rsvd; rdF |-> prdata[31:9] == 23'h0 && prdata[7:5] == 3'h0 && prdata[3:2] == 2'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	// Only a write of one may drop the unmaskable request
	property p_rdone; $fell(resetDoneRequest) |-> $past(clr8, 2); endproperty
	a_rdone: assert property (p_rdone) else $error("reset request lost");
	property p_ovs; rdF && |($past(unreadMsgStatus, 2) & ~$past(unreadMsgStatus, 3)) |-> prdata[1]; endproperty
	a_ovs: assert property (p_ovs) else $error("overwrite not set");
	property p_ovc; rdF && $past(unreadMsgStatus, 2) == 0 && $past(unreadMsgStatus) == 0 |-> !prdata[1]; endproperty
	a_ovc: assert property (p_ovc) else $error("overwrite not cleared");
endmodule // cirq_flags_chk
bind cirq_flags cirq_flags_chk #(.NUM_MBOX(NUM_MBOX)) u_chk (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .unreadMsgStatus(unreadMsgStatus), .resetDoneRequest(resetDoneRequest));

// file: testbench/cirq_tx_model.sv
`timescale 1ns/1ps
module cirq_tx_model
(
	input wire         clk,
	input wire         nrst,
	input wire         go,
	input wire [3:0]   idx,
	output reg [15:0]  txPendingBits,
	output reg [15:0]  txDoneClear
);
	// One slot completes per go; refilled next cycle, a rise that sets nothing
	always @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			txPendingBits <= 16'hffff;
			txDoneClear <= 16'h0;
		end
		else
		begin
			txPendingBits <= go ? ~(16'h1 << idx) : 16'hffff;
			txDoneClear <= go ? (16'h1 << idx) : 16'h0;
		end
endmodule // cirq_tx_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg         clk, nrst, psel, penable, pwrite, sleepMode, busDominant, standbyExit, go, err;
	reg [11:0]  paddr;
	reg [31:0]  pwdata, r;
	reg [15:0]  unreadMsgStatus;
	reg [3:0]   idx;
	wire [31:0] prdata;
	wire        pready, pslverr, rdReq, ovReq, esReq, irq;
	wire [15:0] txPendingBits, txDoneClear;
	integer     fail_count, tests_run, expF, expM;
	cirq_flags DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepMode(sleepMode),
		.busDominant(busDominant), .standbyExit(standbyExit), .unreadMsgStatus(unreadMsgStatus),
		.txPendingBits(txPendingBits), .txDoneClear(txDoneClear), .resetDoneRequest(rdReq),
		.overloadGroupRequest(ovReq), .emptySlotRequest(esReq), .irq(irq));
	cirq_tx_model u_tx (.clk(clk), .nrst(nrst), .go(go), .idx(idx), .txPendingBits(txPendingBits),
		.txDoneClear(txDoneClear));
	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task results;
		$display("Compared %0d, mismatched %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h, want %h", $time, got, exp);
		end
	endtask
	// Bus cycle; no fixed latency assumed, the model tracks flags and mask
	task apb(input [11:0] a, input w, input [31:0] d);
		integer i;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		@(posedge clk);
		while (!pready && i < 16)
		begin
			@(posedge clk);
			i = i + 1;
		end
		if (!pready)
		begin
			fail_count++;
			results();
		end
		r = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		if (w && a == 12'h000) expF = expF & ~(d & 32'h111);
		if (w && a == 12'h004) expM = 32'hffec | (d & 32'h13);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(r, e);
	endtask
	// Requests lag an event by two edges, so look after two falling edges
	task req;
		integer o, s;
		repeat (2) @(negedge clk);
		o = (expF[4] & ~expM[4]) | (expF[1] & ~expM[1]);
		s = expF[0] & ~expM[0];
		chk({irq, ovReq, esReq, rdReq}, {expF[8] | o[0] | s[0], o[0], s[0], expF[8]});
	endtask
	initial
	begin
		{nrst, psel, penable, pwrite, sleepMode, busDominant, standbyExit, go, idx} = 0;
		{paddr, pwdata, unreadMsgStatus} = 0;
		{fail_count, tests_run, expF, expM} = {32'h0, 32'h0, 32'h100, 32'hffff};
		void'($urandom(32'hcd908b1a));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rd(12'h000, expF);
		rd(12'h004, expM);
		req;
		rd(12'h010, 32'h0);
		chk(err, 1'b1);
		$display("reset values done");
		apb(12'h004, 1'b1, 32'h0);
		req;
		apb(12'h000, 1'b1, 32'hffffffee);
		rd(12'h000, expF);
		busDominant <= 1'b1;
		rd(12'h000, expF);
		sleepMode <= 1'b1;
		expF = expF | 32'h10;
		apb(12'h000, 1'b1, 32'h10);
		expF = expF | 32'h10;
		rd(12'h000, expF);
		req;
		{sleepMode, busDominant} <= 2'b00;
		apb(12'h000, 1'b1, 32'h0);
		rd(12'h000, expF);
		apb(12'h000, 1'b1, 32'h10);
		rd(12'h000, expF);
		$display("wake flag done");
		unreadMsgStatus <= 16'h1 << ($urandom % 16);
		expF = expF | 32'h2;
		apb(12'h000, 1'b1, 32'h2);
		rd(12'h000, expF);
		req;
		unreadMsgStatus <= 16'h0;
		expF = expF & ~32'h2;
		rd(12'h000, expF);
		$display("overwrite flag done");
		{go, idx} <= {1'b1, 4'($urandom)};
		@(posedge clk) go <= 1'b0;
		expF = expF | 32'h1;
		rd(12'h000, expF);
		req;
		apb(12'h004, 1'b1, 32'h1);
		req;
		apb(12'h000, 1'b1, 32'h1);
		rd(12'h000, expF);
		$display("slot flag done");
		standbyExit <= 1'b1;
		@(posedge clk) standbyExit <= 1'b0;
		repeat (8) @(posedge clk);
		expF = expF | 32'h100;
		rd(12'h000, expF);
		apb(12'h000, 1'b1, 32'h100);
		apb(12'h008, 1'b1, 32'h1);
		rd(12'h00c, 32'h1);
		repeat (8) @(posedge clk);
		rd(12'h00c, 32'h0);
		rd(12'h008, 32'h0);
		expF = expF | 32'h100;
		rd(12'h000, expF);
		$display("standby done");
		results();
	end
	// Overall watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule // tb_top
